// file: rtl/core_regs_pkg.sv
package core_regs_pkg;

    localparam int NUM_REGS = 32;
    localparam int REG_AW = 5;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Status bit positions
    localparam int BIT_GIE = 7;
    localparam int BIT_TCOPY = 6;
    localparam int BIT_HALF = 5;
    localparam int BIT_SIGN = 4;
    localparam int BIT_OVF = 3;
    localparam int BIT_NEG = 2;
    localparam int BIT_ZERO = 1;
    localparam int BIT_CARRY = 0;

    // Pointer pair low-byte registers
    localparam logic [4:0] PTR_X_LO = 5'h1A;
    localparam logic [4:0] PTR_Y_LO = 5'h1C;
    localparam logic [4:0] PTR_Z_LO = 5'h1E;

    // Data space regions
    localparam logic [15:0] DS_REG_LAST = 16'h001F;
    localparam logic [15:0] DS_IO_FIRST = 16'h0020;
    localparam logic [15:0] DS_IO_LAST = 16'h005F;
    localparam logic [15:0] DS_EXT_FIRST = 16'h0060;
    localparam logic [15:0] DS_EXT_LAST = 16'h00FF;
    localparam logic [5:0] IO_DS_BASE = 6'h20;

    // Stack pointer steps
    localparam logic [15:0] SP_STEP_BYTE = 16'h0001;
    localparam logic [15:0] SP_STEP_RET = 16'h0002;
    localparam logic [15:0] SP_RESET = 16'h01FF;

    typedef enum logic [1:0] {
        PORT_8R_8W,
        PORT_2X8R_8W,
        PORT_2X8R_16W,
        PORT_16R_16W
    } port_mode_type;

    typedef enum logic [2:0] {
        SP_HOLD,
        SP_PUSH1,
        SP_POP1,
        SP_PUSH2,
        SP_POP2,
        SP_LOAD
    } sp_op_type;

    typedef enum logic [1:0] {
        REG_NONE,
        REG_WORKING,
        REG_IO,
        REG_EXTENDED
    } region_type;

    // Flags from the ALU
    typedef struct packed {
        logic half;
        logic ovf;
        logic neg;
        logic zero;
        logic carry;
    } alu_flags_type;

    // Which flags an instruction updates
    typedef struct packed {
        logic half;
        logic ovf;
        logic neg;
        logic zero;
        logic carry;
    } flag_mask_type;

    // Register file port request
    typedef struct packed {
        port_mode_type mode;
        logic [4:0] rd_a;
        logic [4:0] rd_b;
        logic wr_en;
        logic [4:0] wr_addr;
        logic [15:0] wr_data;
    } rf_req_type;

    // Status control requests
    typedef struct packed {
        logic irq_take;
        logic irq_return;
        logic gie_set;
        logic gie_clr;
        logic bit_store;
        logic bit_load;
        logic [2:0] bit_sel;
        logic sw_wr;
        logic [7:0] sw_data;
    } status_ctl_type;

endpackage

// file: rtl/regfile_mem.sv
`timescale 1ns/1ps
module regfile_mem (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] rd_a,
    input wire logic [4:0] rd_b,
    input wire logic [4:0] rd_c,
    input wire logic we_lo,
    input wire logic [4:0] wa_lo,
    input wire logic [7:0] wd_lo,
    input wire logic we_hi,
    input wire logic [4:0] wa_hi,
    input wire logic [7:0] wd_hi,
    output logic [7:0] q_a,
    output logic [7:0] q_b,
    output logic [7:0] q_c,
    output logic [7:0] q_d,
    output logic [255:0] all_q
);
    import core_regs_pkg::*;

    logic [7:0] mem_r [NUM_REGS];

    // Write ports; a written value is visible to the read in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                mem_r[i] <= RESET_BYTE;
            end
        end else begin
            if (we_lo) begin
                mem_r[wa_lo] <= wd_lo;
            end
            if (we_hi) begin
                mem_r[wa_hi] <= wd_hi;
            end
        end
    end

    // Combinational read ports, bypassed from pending writes
    function automatic logic [7:0] rd(input logic [4:0] a, input logic [7:0] m);
        logic [7:0] v;
        v = m;
        if (we_lo && wa_lo == a) begin
            v = wd_lo;
        end
        if (we_hi && wa_hi == a) begin
            v = wd_hi;
        end
        return v;
    endfunction

    always_comb begin
        q_a = rd(rd_a, mem_r[rd_a]);
        q_b = rd(rd_b, mem_r[rd_b]);
        q_c = rd(rd_c, mem_r[rd_c]);
        q_d = rd(rd_a + 5'h01, mem_r[rd_a + 5'h01]);
    end

    // Flat view for pointer taps
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            all_q[i*8 +: 8] = mem_r[i];
        end
    end
endmodule

// file: rtl/status_byte.sv
`timescale 1ns/1ps
module status_byte (
    input wire logic clk,
    input wire logic rst_n,
    input wire core_regs_pkg::status_ctl_type ctl,
    input wire logic alu_valid,
    input wire core_regs_pkg::alu_flags_type flags,
    input wire core_regs_pkg::flag_mask_type fmask,
    input wire logic [7:0] bit_src,
    output logic [7:0] status_q
);
    import core_regs_pkg::*;

    logic [7:0] sr_r;
    logic [7:0] sr_nxt;

    always_comb begin
        sr_nxt = sr_r;
        if (ctl.sw_wr) begin
            sr_nxt = ctl.sw_data;
        end
        // Flags from the last ALU result
        if (alu_valid) begin
            if (fmask.half) sr_nxt[BIT_HALF] = flags.half;
            if (fmask.ovf) sr_nxt[BIT_OVF] = flags.ovf;
            if (fmask.neg) sr_nxt[BIT_NEG] = flags.neg;
            if (fmask.zero) sr_nxt[BIT_ZERO] = flags.zero;
            if (fmask.carry) sr_nxt[BIT_CARRY] = flags.carry;
        end
        if (ctl.bit_store) begin
            sr_nxt[BIT_TCOPY] = bit_src[ctl.bit_sel];
        end
        // Entry beats set, so a simultaneous enable cannot reopen the gate
        if (ctl.gie_set || ctl.irq_return) begin
            sr_nxt[BIT_GIE] = 1'b1;
        end
        if (ctl.gie_clr || ctl.irq_take) begin
            sr_nxt[BIT_GIE] = 1'b0;
        end
        // Sign kept consistent whatever updated the other bits
        sr_nxt[BIT_SIGN] = sr_nxt[BIT_NEG] ^ sr_nxt[BIT_OVF];
    end

    // No save or restore on interrupts; software owns that
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sr_r <= STATUS_RESET;
        end else begin
            sr_r <= sr_nxt;
        end
    end

    assign status_q = sr_r;
endmodule

// file: rtl/cpu_register_file_and_status.sv
`timescale 1ns/1ps
module cpu_register_file_and_status (
    input wire logic MCLK,
    input wire logic NRST,
    input wire core_regs_pkg::rf_req_type RF_REQ,
    input wire logic ALU_VALID,
    input wire core_regs_pkg::alu_flags_type ALU_FLAGS,
    input wire core_regs_pkg::flag_mask_type FLAG_MASK,
    input wire core_regs_pkg::status_ctl_type STATUS_CTL,
    input wire logic [15:0] DS_ADDR,
    input wire logic DS_WR,
    input wire logic DS_RD,
    input wire logic [7:0] DS_WDATA,
    input wire logic IO_DIRECT,
    input wire logic [5:0] IO_ADDR,
    input wire core_regs_pkg::sp_op_type SP_OP,
    input wire logic [15:0] SP_LOAD_VAL,
    input wire logic [7:0] IRQ_PEND,
    input wire logic FETCH_EN,
    input wire logic [15:0] FETCH_WORD,
    input wire logic [15:0] PC_IN,
    output logic [7:0] OPA,
    output logic [7:0] OPB,
    output logic [15:0] OPW,
    output logic [15:0] PTR_X,
    output logic [15:0] PTR_Y,
    output logic [15:0] PTR_Z,
    output logic [7:0] DS_RDATA,
    output logic DS_HIT_REG,
    output logic [15:0] PERIPH_ADDR,
    output logic PERIPH_WR,
    output logic PERIPH_RD,
    output logic [7:0] PERIPH_WDATA,
    output logic [1:0] PERIPH_REGION,
    output logic [7:0] STATUS,
    output logic IRQ_GO,
    output logic [2:0] IRQ_NUM,
    output logic [15:0] STACK_PTR,
    output logic [15:0] STACK_PUSH_DATA,
    output logic [15:0] IR,
    output logic IR_LONG
);
    import core_regs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Data space decode
    region_type region;
    logic [15:0] eff_addr;
    logic ds_to_reg;
    logic ds_illegal;

    // Direct I/O number maps onto the window just above the registers
    always_comb begin
        if (IO_DIRECT) begin
            eff_addr = {10'h000, IO_ADDR} + {10'h000, IO_DS_BASE};
        end else begin
            eff_addr = DS_ADDR;
        end
        if (eff_addr <= DS_REG_LAST) begin
            region = REG_WORKING;
        end else if (eff_addr >= DS_IO_FIRST && eff_addr <= DS_IO_LAST) begin
            region = REG_IO;
        end else if (eff_addr >= DS_EXT_FIRST && eff_addr <= DS_EXT_LAST) begin
            region = REG_EXTENDED;
        end else begin
            region = REG_NONE;
        end
        // Direct I/O cannot reach the extended range by construction
        ds_illegal = IO_DIRECT && region == REG_EXTENDED;
        ds_to_reg = region == REG_WORKING && !IO_DIRECT;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file ports
    logic we_lo;
    logic we_hi;
    logic [4:0] wa_lo;
    logic [4:0] wa_hi;
    logic [7:0] wd_lo;
    logic [7:0] wd_hi;
    logic [7:0] q_a;
    logic [7:0] q_b;
    logic [7:0] q_c;
    logic [7:0] q_d;
    logic [255:0] all_q;
    logic [7:0] load_val;
    logic [4:0] ds_reg_idx;

    assign ds_reg_idx = eff_addr[4:0];

    // Bit-load rewrites one bit of the addressed register from the copy bit
    always_comb begin
        // Raw cell value: the bypassed port would loop back through this write
        load_val = all_q[RF_REQ.rd_a * 8 +: 8];
        load_val[STATUS_CTL.bit_sel] = STATUS[BIT_TCOPY];
    end

    // Write port selection per port mode; data space write has lowest priority
    always_comb begin
        we_lo = 1'b0;
        we_hi = 1'b0;
        wa_lo = RF_REQ.wr_addr;
        wa_hi = RF_REQ.wr_addr + 5'h01;
        wd_lo = RF_REQ.wr_data[7:0];
        wd_hi = RF_REQ.wr_data[15:8];
        if (STATUS_CTL.bit_load) begin
            we_lo = 1'b1;
            wa_lo = RF_REQ.rd_a;
            wd_lo = load_val;
        end else if (RF_REQ.wr_en) begin
            we_lo = 1'b1;
            we_hi = RF_REQ.mode == PORT_2X8R_16W || RF_REQ.mode == PORT_16R_16W;
        end else if (DS_WR && ds_to_reg) begin
            we_lo = 1'b1;
            wa_lo = ds_reg_idx;
            wd_lo = DS_WDATA;
        end
    end

    regfile_mem u_mem (
        .clk(MCLK),
        .rst_n(NRST),
        .rd_a(RF_REQ.rd_a),
        .rd_b(RF_REQ.rd_b),
        .rd_c(ds_reg_idx),
        .we_lo(we_lo),
        .wa_lo(wa_lo),
        .wd_lo(wd_lo),
        .we_hi(we_hi),
        .wa_hi(wa_hi),
        .wd_hi(wd_hi),
        .q_a(q_a),
        .q_b(q_b),
        .q_c(q_c),
        .q_d(q_d),
        .all_q(all_q)
    );

    // Operand registers: reads follow the port mode
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            OPA <= RESET_BYTE;
            OPB <= RESET_BYTE;
            OPW <= 16'h0000;
        end else begin
            OPA <= q_a;
            OPB <= (RF_REQ.mode == PORT_8R_8W || RF_REQ.mode == PORT_16R_16W) ?
                   RESET_BYTE : q_b;
            OPW <= (RF_REQ.mode == PORT_16R_16W) ? {q_d, q_a} : 16'h0000;
        end
    end

    // Pointer pairs X, Y and Z, read from the raw cells
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            PTR_X <= 16'h0000;
            PTR_Y <= 16'h0000;
            PTR_Z <= 16'h0000;
        end else begin
            PTR_X <= {all_q[(PTR_X_LO+5'h01)*8 +: 8], all_q[PTR_X_LO*8 +: 8]};
            PTR_Y <= {all_q[(PTR_Y_LO+5'h01)*8 +: 8], all_q[PTR_Y_LO*8 +: 8]};
            PTR_Z <= {all_q[(PTR_Z_LO+5'h01)*8 +: 8], all_q[PTR_Z_LO*8 +: 8]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data space read and peripheral forwarding
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            DS_RDATA <= RESET_BYTE;
            DS_HIT_REG <= 1'b0;
        end else begin
            DS_RDATA <= (DS_RD && ds_to_reg) ? q_c : RESET_BYTE;
            DS_HIT_REG <= DS_RD && ds_to_reg;
        end
    end

    // Accesses in the I/O and extended windows go to the peripheral bus
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            PERIPH_ADDR <= 16'h0000;
            PERIPH_WR <= 1'b0;
            PERIPH_RD <= 1'b0;
            PERIPH_WDATA <= RESET_BYTE;
            PERIPH_REGION <= REG_NONE;
        end else begin
            PERIPH_ADDR <= eff_addr;
            PERIPH_WR <= DS_WR && !ds_to_reg && !ds_illegal && region != REG_NONE;
            PERIPH_RD <= DS_RD && !ds_to_reg && !ds_illegal && region != REG_NONE;
            PERIPH_WDATA <= DS_WDATA;
            PERIPH_REGION <= region;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status byte
    logic [7:0] status_q;

    status_byte u_status (
        .clk(MCLK),
        .rst_n(NRST),
        .ctl(STATUS_CTL),
        .alu_valid(ALU_VALID),
        .flags(ALU_FLAGS),
        .fmask(FLAG_MASK),
        .bit_src(q_a),
        .status_q(status_q)
    );

    assign STATUS = status_q;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt arbitration: lowest index wins
    logic [2:0] irq_win;
    logic irq_any;

    always_comb begin
        irq_win = 3'h0;
        irq_any = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            if (IRQ_PEND[i]) begin
                irq_win = 3'(i);
                irq_any = 1'b1;
            end
        end
    end

    // Global enable gates every source; a clear in flight also blocks
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            IRQ_GO <= 1'b0;
            IRQ_NUM <= 3'h0;
        end else begin
            IRQ_GO <= irq_any && status_q[BIT_GIE] && !STATUS_CTL.gie_clr
                      && !STATUS_CTL.irq_take;
            IRQ_NUM <= irq_win;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stack pointer
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            STACK_PTR <= SP_RESET;
        end else begin
            unique case (SP_OP)
                SP_HOLD: STACK_PTR <= STACK_PTR;
                SP_PUSH1: STACK_PTR <= STACK_PTR - SP_STEP_BYTE;
                SP_POP1: STACK_PTR <= STACK_PTR + SP_STEP_BYTE;
                SP_PUSH2: STACK_PTR <= STACK_PTR - SP_STEP_RET;
                SP_POP2: STACK_PTR <= STACK_PTR + SP_STEP_RET;
                SP_LOAD: STACK_PTR <= SP_LOAD_VAL;
                default: STACK_PTR <= STACK_PTR;
            endcase
        end
    end

    // Return address captured for the push on call or interrupt
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            STACK_PUSH_DATA <= 16'h0000;
        end else if (SP_OP == SP_PUSH2) begin
            STACK_PUSH_DATA <= PC_IN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prefetch stage: the next word is latched while this one executes
    logic long_pending_r;

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            IR <= 16'h0000;
            IR_LONG <= 1'b0;
            long_pending_r <= 1'b0;
        end else if (FETCH_EN) begin
            IR <= FETCH_WORD;
            // Second word of a 32-bit instruction is flagged, not decoded
            IR_LONG <= long_pending_r;
            long_pending_r <= !long_pending_r && FETCH_WORD[15:10] == 6'h25
                              && FETCH_WORD[3:2] == 2'h3;
        end
    end
endmodule

// file: verif/alu_partner.sv
`timescale 1ns/1ps
module alu_partner (
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    output core_regs_pkg::alu_flags_type flags
);
    import core_regs_pkg::*;
    logic [8:0] sum;
    logic [4:0] low;
    ////////////////////////////////////////////////////////////////////////////////
    // Add only: the bench needs no other ALU family to drive the flags
    assign sum = {1'b0, a} + {1'b0, b};
    assign low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    assign flags.half = low[4];
    assign flags.ovf = (a[7] == b[7]) && (sum[7] != a[7]);
    assign flags.neg = sum[7];
    assign flags.zero = (sum[7:0] == 8'h00);
    assign flags.carry = sum[8];
endmodule

// file: verif/regs_properties.sv
`timescale 1ns/1ps
module regs_properties (
    input wire logic MCLK,
    input wire logic NRST,
    input wire core_regs_pkg::rf_req_type RF_REQ,
    input wire logic ALU_VALID,
    input wire core_regs_pkg::alu_flags_type ALU_FLAGS,
    input wire core_regs_pkg::flag_mask_type FLAG_MASK,
    input wire core_regs_pkg::status_ctl_type STATUS_CTL,
    input wire logic [15:0] DS_ADDR,
    input wire logic DS_RD,
    input wire logic IO_DIRECT,
    input wire core_regs_pkg::sp_op_type SP_OP,
    input wire logic [7:0] IRQ_PEND,
    input wire logic FETCH_EN,
    input wire logic [15:0] FETCH_WORD,
    input wire logic [7:0] OPA,
    input wire logic [15:0] PERIPH_ADDR,
    input wire logic PERIPH_RD,
    input wire logic [1:0] PERIPH_REGION,
    input wire logic [7:0] STATUS,
    input wire logic IRQ_GO,
    input wire logic [2:0] IRQ_NUM,
    input wire logic [15:0] STACK_PTR,
    input wire logic [15:0] IR
);
    import core_regs_pkg::*;
    logic [2:0] low_r;
    logic [2:0] low_nxt;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!NRST);
    ////////////////////////////////////////////////////////////////////////////////
    // Lowest pending line, the one that must win
    always_comb begin
        low_nxt = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (IRQ_PEND[i]) begin
                low_nxt = 3'(i);
            end
        end
    end
    // Registered to line up with the registered grant
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            low_r <= 3'h0;
        end else begin
            low_r <= low_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    sign_bit_a: assert property (
        STATUS[BIT_SIGN] == (STATUS[BIT_NEG] ^ STATUS[BIT_OVF]))
        else $error("sign bit differs from neg xor ovf");
    alu_flags_a: assert property (ALU_VALID && FLAG_MASK == 5'h1F |=>
        {STATUS[BIT_HALF], STATUS[BIT_OVF:BIT_CARRY]} == $past(ALU_FLAGS)) else $error("flags lost");
    gie_clear_a: assert property (STATUS_CTL.irq_take || STATUS_CTL.gie_clr |=>
        !STATUS[BIT_GIE]) else $error("enable not cleared");
    gie_set_a: assert property ((STATUS_CTL.gie_set || STATUS_CTL.irq_return) &&
        !STATUS_CTL.irq_take && !STATUS_CTL.gie_clr |=> STATUS[BIT_GIE]) else $error("enable not set");
    irq_block_a: assert property (IRQ_GO |-> $past(STATUS[BIT_GIE]) && $past(IRQ_PEND) != 8'h00)
        else $error("interrupt granted while disabled");
    irq_prio_a: assert property (IRQ_GO |-> IRQ_NUM == low_r)
        else $error("wrong interrupt priority");
    sp_push2_a: assert property (SP_OP == SP_PUSH2 |=>
        STACK_PTR == $past(STACK_PTR) - SP_STEP_RET)
        else $error("stack pointer step wrong");
    write_bypass_a: assert property (RF_REQ.wr_en && RF_REQ.mode == PORT_8R_8W &&
        !STATUS_CTL.bit_load && RF_REQ.rd_a == RF_REQ.wr_addr |=>
        OPA == $past(RF_REQ.wr_data[7:0])) else $error("no bypass");
    io_region_a: assert property (DS_RD && !IO_DIRECT &&
        DS_ADDR inside {[DS_IO_FIRST:DS_IO_LAST]}
        |=> PERIPH_RD && PERIPH_REGION == REG_IO && PERIPH_ADDR == $past(DS_ADDR))
        else $error("io window not forwarded");
    ext_region_a: assert property (DS_RD && !IO_DIRECT &&
        DS_ADDR inside {[DS_EXT_FIRST:DS_EXT_LAST]} |=> PERIPH_REGION == REG_EXTENDED)
        else $error("extended window not marked");
    fetch_ir_a: assert property (FETCH_EN |=> IR == $past(FETCH_WORD))
        else $error("fetched word not latched");
endmodule

bind cpu_register_file_and_status regs_properties chk (.MCLK(MCLK), .NRST(NRST), .RF_REQ(RF_REQ),
    .ALU_VALID(ALU_VALID), .ALU_FLAGS(ALU_FLAGS), .FLAG_MASK(FLAG_MASK), .STATUS_CTL(STATUS_CTL),
    .DS_ADDR(DS_ADDR), .DS_RD(DS_RD), .IO_DIRECT(IO_DIRECT), .SP_OP(SP_OP), .IRQ_PEND(IRQ_PEND),
    .FETCH_EN(FETCH_EN), .FETCH_WORD(FETCH_WORD), .OPA(OPA), .PERIPH_ADDR(PERIPH_ADDR),
    .PERIPH_RD(PERIPH_RD), .PERIPH_REGION(PERIPH_REGION), .STATUS(STATUS), .IRQ_GO(IRQ_GO),
    .IRQ_NUM(IRQ_NUM), .STACK_PTR(STACK_PTR), .IR(IR));

// file: verif/tb_cpu_register_file_and_status.sv
`timescale 1ns/1ps
module tb_cpu_register_file_and_status;
    import core_regs_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    rf_req_type rf_req = '0;
    logic alu_valid = 1'b0;
    logic [7:0] alu_a = 8'h00;
    logic [7:0] alu_b = 8'h00;
    alu_flags_type alu_flags;
    status_ctl_type status_ctl = '0;
    logic [15:0] ds_addr = 16'h0000;
    logic ds_wr = 1'b0;
    logic ds_rd = 1'b0;
    logic [7:0] ds_wdata = 8'h00;
    logic io_direct = 1'b0;
    logic [5:0] io_addr = 6'h00;
    sp_op_type sp_op = SP_HOLD;
    logic [7:0] irq_pend = 8'h00;
    logic fetch_en = 1'b0;
    logic [15:0] fetch_word = 16'h0000;
    logic [7:0] opa, opb, ds_rdata, periph_wdata, status;
    logic [15:0] opw, ptr_x, ptr_y, ptr_z, periph_addr, stack_ptr, ir;
    logic ds_hit_reg, periph_wr, periph_rd, irq_go, ir_long;
    logic [1:0] region;
    logic [15:0] push_data;
    logic [2:0] irq_num;
    int errors = 0;
    int cmp_count = 0;
    logic [15:0] pv [3] = '{16'h1A2B, 16'hC3D4, 16'hE5F6};
    logic [15:0] aa [4] = '{16'h0020, 16'h005F, 16'h0060, 16'h00FF};
    region_type rg [4] = '{REG_IO, REG_IO, REG_EXTENDED, REG_EXTENDED};
    logic [7:0] sa [3] = '{8'h7F, 8'hFF, 8'h80};
    logic [7:0] sb [3] = '{8'h01, 8'h01, 8'h80};
    logic [7:0] se [3] = '{8'h2C, 8'h23, 8'h1B};
    logic [3:0] cs [4] = '{4'b0010, 4'b1000, 4'b0100, 4'b0001};
    logic [7:0] ce [4] = '{8'h9B, 8'h1B, 8'h9B, 8'h1B};
    sp_op_type so [5] = '{SP_LOAD, SP_POP1, SP_PUSH2, SP_POP2, SP_PUSH1};
    logic [15:0] sx [5] = '{16'h0200, 16'h0201, 16'h01FF, 16'h0201, 16'h0200};
    logic [15:0] fw [4] = '{16'h940C, 16'h1234, 16'h0F01, 16'h0000};
    logic fl [3] = '{1'b0, 1'b1, 1'b0};
    ////////////////////////////////////////////////////////////////////////////////
    always #12.5 mclk = ~mclk;
    alu_partner alu (.a(alu_a), .b(alu_b), .flags(alu_flags));
    cpu_register_file_and_status dut (.MCLK(mclk), .NRST(nrst), .RF_REQ(rf_req),
        .ALU_VALID(alu_valid), .ALU_FLAGS(alu_flags), .FLAG_MASK(5'h1F), .STATUS_CTL(status_ctl),
        .DS_ADDR(ds_addr), .DS_WR(ds_wr), .DS_RD(ds_rd), .DS_WDATA(ds_wdata),
        .IO_DIRECT(io_direct), .IO_ADDR(io_addr), .SP_OP(sp_op), .SP_LOAD_VAL(16'h0200),
        .IRQ_PEND(irq_pend), .FETCH_EN(fetch_en), .FETCH_WORD(fetch_word), .PC_IN(16'h0ABC),
        .OPA(opa), .OPB(opb), .OPW(opw), .PTR_X(ptr_x), .PTR_Y(ptr_y), .PTR_Z(ptr_z),
        .DS_RDATA(ds_rdata), .DS_HIT_REG(ds_hit_reg), .PERIPH_ADDR(periph_addr),
        .PERIPH_WR(periph_wr), .PERIPH_RD(periph_rd), .PERIPH_WDATA(periph_wdata),
        .PERIPH_REGION(region), .STATUS(status), .IRQ_GO(irq_go), .IRQ_NUM(irq_num),
        .STACK_PTR(stack_ptr), .STACK_PUSH_DATA(push_data), .IR(ir), .IR_LONG(ir_long));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] val(input int i);
        return 8'(i) * 8'h25 + 8'h05;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Sample edge: pulses drop here, then outputs settle for the caller
    task automatic done_op();
        @(posedge mclk);
        rf_req.wr_en <= 1'b0;
        ds_rd <= 1'b0;
        ds_wr <= 1'b0;
        alu_valid <= 1'b0;
        status_ctl <= '0;
        sp_op <= SP_HOLD;
        #1;
    endtask
    task automatic rf(input port_mode_type m, input logic [4:0] ra, input logic [4:0] rb,
                      input logic we, input logic [4:0] wa, input logic [15:0] wd);
        @(posedge mclk);
        rf_req <= '{mode: m, rd_a: ra, rd_b: rb, wr_en: we, wr_addr: wa, wr_data: wd};
        done_op();
    endtask
    task automatic ds(input logic [15:0] a, input logic w, input logic [7:0] d, input logic dir);
        @(posedge mclk);
        ds_addr <= a;
        io_addr <= a[5:0];
        io_direct <= dir;
        ds_rd <= !w;
        ds_wr <= w;
        ds_wdata <= d;
        done_op();
    endtask
    task automatic ctl(input logic [3:0] s);
        @(posedge mclk);
        status_ctl <= '{irq_take: s[3], irq_return: s[2], gie_set: s[1], gie_clr: s[0],
                        default: '0};
        done_op();
    endtask
    task automatic give_verdict();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge mclk);
        errors++;
        give_verdict();
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        #1;
        chk({status, opa, stack_ptr}, {8'h00, 8'h00, 16'h01FF});
        for (int i = 0; i < 32; i++) begin
            rf(PORT_8R_8W, 5'(i), 5'h00, 1'b1, 5'(i), {8'h00, val(i)});
            chk(32'(opa), 32'(val(i)));
        end
        for (int i = 0; i < 32; i++) begin
            rf(PORT_2X8R_8W, 5'(i), 5'(31 - i), 1'b0, 5'h00, 16'h0000);
            chk(32'({opa, opb}), 32'({val(i), val(31 - i)}));
        end
        for (int k = 0; k < 3; k++) begin
            rf(PORT_2X8R_16W, 5'h00, 5'h00, 1'b1, PTR_X_LO + 5'(2 * k), pv[k]);
        end
        // Pointers follow the registers one cycle late
        @(posedge mclk);
        #1;
        chk({ptr_x, ptr_y}, {pv[0], pv[1]});
        chk(32'(ptr_z), 32'(pv[2]));
        rf(PORT_16R_16W, PTR_Y_LO, 5'h00, 1'b0, 5'h00, 16'h0000);
        chk({opb, opw}, {8'h00, pv[1]});
        ds(16'h001E, 1'b0, 8'h00, 1'b0);
        chk({ds_hit_reg, ds_rdata}, {1'b1, pv[2][7:0]});
        ds(16'h0005, 1'b1, 8'h3C, 1'b0);
        rf(PORT_8R_8W, 5'h05, 5'h00, 1'b0, 5'h00, 16'h0000);
        chk(32'(opa), 32'h3C);
        for (int j = 0; j < 4; j++) begin
            ds(aa[j], 1'b0, 8'h00, 1'b0);
            chk(32'({periph_rd, region, periph_addr}), 32'({1'b1, rg[j], aa[j]}));
        end
        ds(16'h003F, 1'b1, 8'h5A, 1'b1);
        chk({periph_wr, region, periph_addr, periph_wdata},
            {1'b1, REG_IO, 16'h005F, 8'h5A});
        for (int k = 0; k < 3; k++) begin
            @(posedge mclk);
            alu_a <= sa[k];
            alu_b <= sb[k];
            alu_valid <= 1'b1;
            done_op();
            chk(32'(status), 32'(se[k]));
        end
        @(posedge mclk);
        irq_pend <= 8'h0C;
        for (int k = 0; k < 4; k++) begin
            ctl(cs[k]);
            chk(32'(status), 32'(ce[k]));
            if (k == 1) chk(32'(irq_go), 32'h0);
            if (k == 0 || k == 3) begin
                @(posedge mclk);
                #1;
                chk(32'(irq_go), 32'(k == 0));
                if (k == 0) chk(32'(irq_num), 32'h2);
            end
        end
        // Copy bit 2 of r5 (0x3C) into the copy store, then into bit 0 of r5
        @(posedge mclk);
        status_ctl <= '{bit_store: 1'b1, bit_sel: 3'h2, default: '0};
        done_op();
        chk(32'(status), 32'h5B);
        @(posedge mclk);
        status_ctl <= '{bit_load: 1'b1, bit_sel: 3'h0, default: '0};
        done_op();
        chk(32'(opa), 32'h3D);
        for (int k = 0; k < 5; k++) begin
            @(posedge mclk);
            sp_op <= so[k];
            done_op();
            chk(32'(stack_ptr), 32'(sx[k]));
            if (k == 2) chk(32'(push_data), 32'h0ABC);
        end
        // Back to back fetches; the long-word marker lands on the second word
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            fetch_en <= (i < 3);
            fetch_word <= fw[i];
            #1;
            if (i > 0) chk(32'({ir_long, ir}), 32'({fl[i - 1], fw[i - 1]}));
        end
        @(posedge mclk);
        nrst <= 1'b0;
        @(posedge mclk);
        nrst <= 1'b1;
        #1;
        chk(32'({status, stack_ptr}), {8'h00, 8'h00, 16'h01FF});
        give_verdict();
    end
endmodule
